// ===== bench/ibcd_ctl_model.sv
// behavioural active controller: command and data bytes, both polls
`timescale 1ns/10ps
module ibcd_ctl_model (
    input  wire       clock,
    input  wire [7:0] dio_bus,
    output reg        atn_n     = 1'b1,
    output reg        eoi_n     = 1'b1,
    output reg  [7:0] dio_drv   = 8'hff,
    output reg        byte_done = 1'b0
);
    // one byte per call, so chained calls give back-to-back bytes
    task xfer(input logic c, input logic [7:0] b);
        atn_n = ~c;
        dio_drv = ~b;
        byte_done = 1'b1;
        @(posedge clock) #1;
    endtask
    // a released line reads at its pull-up level, never the last byte
    task idle;
        byte_done = 1'b0;
        dio_drv = 8'hff;
        @(posedge clock) #1;
    endtask
    task ppoll(output logic [7:0] seen);
        atn_n = 1'b0;
        eoi_n = 1'b0;
        repeat (3) idle;
        seen = ~dio_bus;
        eoi_n = 1'b1;
        idle;
    endtask
    // atn is taken low a cycle before the next command so the status drive is gone
    task sread(output logic [7:0] stb);
        atn_n = 1'b1;
        repeat (3) idle;
        stb = ~dio_bus;
        byte_done = 1'b1;
        @(posedge clock) #1;
        atn_n = 1'b0;
        idle;
    endtask
endmodule

// ===== bench/ibcd_decoder_properties.sv
// assertion checker on the bus command decoder ports
`timescale 1ns/10ps
module ibcd_props #(
    parameter ADDR_W = 5
) (
    input wire              clock,
    input wire              rst,
    input wire              atn_n,
    input wire              eoi_n,
    input wire              byte_done,
    input wire              svc_set,
    input wire [ADDR_W-1:0] my_addr,
    input wire [ADDR_W-1:0] my_sec,
    input wire [7:0]        dio_n_in,
    input wire [7:0]        stb_in,
    input wire [7:0]        dio_n_out,
    input wire [7:0]        dio_oe,
    input wire [7:0]        rx_data,
    input wire              srq_n_out,
    input wire              srq_oe,
    input wire              rx_valid,
    input wire              listen,
    input wire              talk,
    input wire              spoll_mode,
    input wire              pp_enabled,
    input wire              lockout,
    input wire              dev_clear,
    input wire              go_local,
    input wire              trigger,
    input wire              take_ctrl,
    input wire              cmd_ignored,
    input wire              stb_sent
);
    // bit 7 of a command byte carries no meaning
    wire [6:0] cmd  = ~dio_n_in[6:0];
    wire       take = byte_done & ~atn_n;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_get; take && cmd == 7'h08 && listen ##1 listen |=> trigger; endproperty
    a_get: assert property (p_get) else $error("trigger missing");
    property p_ign; take && cmd == 7'h08 && !listen ##1 !listen |=> cmd_ignored && !trigger;
    endproperty
    a_ign: assert property (p_ign) else $error("addressed command not refused");
    property p_llo; take && cmd == 7'h11 |-> ##2 lockout; endproperty
    a_llo: assert property (p_llo) else $error("lockout not set");
    property p_dcl; take && cmd == 7'h14 |-> ##2 dev_clear; endproperty
    a_dcl: assert property (p_dcl) else $error("device clear missing");
    property p_ppu; take && cmd == 7'h15 |-> ##2 !pp_enabled; endproperty
    a_ppu: assert property (p_ppu) else $error("poll setup kept");
    property p_srq; svc_set |-> ##2 srq_oe && !srq_n_out; endproperty
    a_srq: assert property (p_srq) else $error("service request not driven");
    property p_rx;
        byte_done && atn_n && listen && !(talk && spoll_mode) |=>
            rx_valid && rx_data == ~$past(dio_n_in);
    endproperty
    a_rx: assert property (p_rx) else $error("data byte not passed on");
    property p_pp; !atn_n && !eoi_n && pp_enabled |=> $onehot0(dio_oe) && dio_oe == ~dio_n_out;
    endproperty
    a_pp: assert property (p_pp) else $error("poll answer on several lines");
endmodule
bind ibcd_decoder ibcd_props #(.ADDR_W(ADDR_W)) u_props (.*);

// ===== bench/tb_ibcd_decoder.sv
// self-checking bench for the bus command decoder
`timescale 1ns/10ps
module tb_ibcd_decoder;
    logic        clock   = 1'b0;
    logic        rst     = 1'b1;
    logic [4:0]  my_addr = 5'h00;
    logic [4:0]  my_sec  = 5'h00;
    logic [7:0]  stb_in  = 8'h00;
    logic        svc_set = 1'b0;
    wire         atn_n, eoi_n, byte_done, srq_n_out, srq_oe, rx_valid, listen, talk;
    wire         spoll_mode, pp_enabled, lockout, dev_clear, go_local, trigger, take_ctrl;
    wire         cmd_ignored, stb_sent;
    wire  [7:0]  dio_drv, dio_n_out, dio_oe, rx_data;
    wire  [7:0]  dio_bus = dio_drv & (dio_n_out | ~dio_oe);
    wire  [6:0]  ev  = {rx_valid, dev_clear, go_local, trigger, take_ctrl, cmd_ignored, stb_sent};
    wire  [7:0]  lvl = {listen, talk, spoll_mode, pp_enabled, lockout, srq_oe, ~srq_n_out, 1'b0};
    logic [15:0] expq [$];
    logic [15:0] e_head;
    logic [7:0]  got, line;
    logic [7:0]  codes [5] = '{8'h01, 8'h04, 8'h08, 8'h09, 8'h06};
    logic [6:0]  kinds [5] = '{7'h10, 7'h20, 7'h08, 7'h04, 7'h02};
    int          failures = 0;
    int          n_tests  = 0;
    int          i;
    ibcd_decoder dut (.dio_n_in(dio_bus), .*);
    ibcd_ctl_model ctl (.*);
    initial begin
        forever #5 clock = ~clock;
    end
    task cmp_evt(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    task cmp_val(input logic [7:0] g, input logic [7:0] e);
        cmp_evt({8'h00, g}, {8'h00, e});
    endtask
    task send(input logic [7:0] b, input logic [6:0] k);
        if (k != 7'h00) begin
            expq.push_back({1'b0, k, 8'h00});
        end
        ctl.xfer(1'b1, b);
    endtask
    task dat(input logic [7:0] b);
        expq.push_back({8'h40, b});
        ctl.xfer(1'b0, b);
    endtask
    task end_of_test;
        if (failures == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // any pulse with no note queued is compared against an impossible value
    always @(negedge clock) begin
        if (ev !== 7'h00) begin
            e_head = (expq.size() > 0) ? expq.pop_front() : 16'hffff;
            cmp_evt({1'b0, ev, rx_valid ? rx_data : 8'h00}, e_head);
        end
    end
    initial begin
        #20000;
        failures++;
        end_of_test;
    end
    initial begin
        line = 8'($urandom(33) % 8);
        my_addr = 5'($urandom % 30);
        stb_in = 8'($urandom);
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        cmp_val(lvl, 8'h00);
        ctl.xfer(1'b0, 8'h5a);
        send(8'h02, 7'h02);
        send(8'h63, 7'h02);
        send(8'h08, 7'h02);
        send(8'h11, 7'h00);
        send(8'h14, 7'h20);
        send({3'h1, my_addr}, 7'h00);
        ctl.idle;
        for (i = 0; i < 5; i++) send(codes[i], kinds[i]);
        ctl.idle;
        for (i = 0; i < 4; i++) dat(8'($urandom));
        dat(8'h14);
        ctl.idle;
        cmp_val(lvl, 8'h88);
        send(8'h05, 7'h00);
        send(8'h60 | line, 7'h00);
        ctl.ppoll(got);
        cmp_val(got, 8'h01 << line);
        cmp_val(lvl, 8'h98);
        send(8'h15, 7'h00);
        ctl.ppoll(got);
        cmp_val(got, 8'h00);
        svc_set = 1'b1;
        ctl.idle;
        svc_set = 1'b0;
        ctl.idle;
        cmp_val(lvl, 8'h8e);
        send(8'h18, 7'h00);
        send({3'h2, my_addr}, 7'h01);
        ctl.sread(got);
        send(8'h19, 7'h00);
        repeat (2) ctl.idle;
        cmp_val(got, {stb_in[7], 1'b1, stb_in[5:0]});
        cmp_val(lvl, 8'hc8);
        send(8'h5f, 7'h00);
        send(8'h3f, 7'h00);
        repeat (2) ctl.idle;
        cmp_val(lvl, 8'h08);
        cmp_val(8'(expq.size()), 8'h00);
        end_of_test;
    end
endmodule

// ===== src/ibcd_decoder.v
// ieee-488 bus command decoder, device side
`timescale 1ns/10ps
`include "ibcd_map.vh"

// Behaviour
// - atn asserted means command, else data
// - addressed commands only when addressed as listener
// - data mode bytes passed on, no meaning
// - unknown command codes ignored, flagged by a cmd_ignored pulse
// - local lockout disables local key
// - device clear resets function logic, everyone
// - parallel poll unconfigure drops poll setup
// - selected device clear for addressed listener
// - go to local for addressed listener
// - group execute trigger for addressed listener
// - parallel poll configure opens response assignment
// - take control hands controller role over
// - unlisten drops listener addressed state
// - untalk drops talker addressed state
// - service request drives srq low
// - status byte bit six flags service request
// - poll response assigned to one data line
// - atn with eoi triggers parallel poll answer
// - secondary byte: extended address or poll enable
module ibcd_decoder #(
    parameter ADDR_W      = 5,
    parameter EXT_ADDR_EN = 1'b0
) (
    input  wire              clock,
    input  wire              rst,
    input  wire [ADDR_W-1:0] my_addr,
    input  wire [ADDR_W-1:0] my_sec,
    input  wire              atn_n,
    input  wire              eoi_n,
    input  wire [7:0]        dio_n_in,
    input  wire              byte_done,
    input  wire [7:0]        stb_in,
    input  wire              svc_set,
    output wire [7:0]        dio_n_out,
    output wire [7:0]        dio_oe,
    output wire              srq_n_out,
    output wire              srq_oe,
    output wire [7:0]        rx_data,
    output wire              rx_valid,
    output wire              listen,
    output wire              talk,
    output wire              spoll_mode,
    output wire              pp_enabled,
    output wire              lockout,
    output wire              dev_clear,
    output wire              go_local,
    output wire              trigger,
    output wire              take_ctrl,
    output wire              cmd_ignored,
    output wire              stb_sent
);

    // true when byte b carries group grp and the low address bits equal a
    function addr_hit;
        input [6:0]        b;
        input [1:0]        grp;
        input [ADDR_W-1:0] a;
        begin
            addr_hit = (b[`IBCD_GRP_MSB:`IBCD_GRP_LSB] == grp) &&
                       (b[`IBCD_ADDR_MSB:0] == a);
        end
    endfunction

    reg  [6:0] cmd_r;
    reg        cmd_v_r;
    reg  [7:0] rx_data_r;
    reg        rx_valid_r;
    reg        listen_r;
    reg        talk_r;
    reg        lpend_r;
    reg        tpend_r;
    reg        ppc_pend_r;
    reg        spoll_r;
    reg        ppen_r;
    reg        ppl_sense_r;
    reg  [2:0] ppl_line_r;
    reg        lockout_r;
    reg        dev_clear_r;
    reg        go_local_r;
    reg        trigger_r;
    reg        take_ctrl_r;
    reg        cmd_ignored_r;
    reg        stb_sent_r;
    reg        rsv_r;
    reg  [7:0] dio_oe_r;
    reg  [7:0] dio_n_out_r;
    reg        srq_oe_r;
    reg        srq_n_out_r;

    wire [1:0] grp       = cmd_r[`IBCD_GRP_MSB:`IBCD_GRP_LSB];
    wire       cmd_take  = byte_done & ~atn_n;
    wire       stb_src   = atn_n & talk_r & spoll_r;
    wire       stb_taken = byte_done & stb_src;
    wire       pp_active = ~atn_n & ~eoi_n & ppen_r;
    wire [7:0] stb_byte;
    wire       ist_match = (rsv_r == ppl_sense_r);
    wire [7:0] pp_drive;

    // one line per device; several devices may share a line on the bus
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_ppl
            assign pp_drive[gi] = pp_active & ist_match & (ppl_line_r == gi);
        end
    endgenerate

    // status byte: every bit from the instrument except the request bit
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_stb
            if (gi == `IBCD_STB_RSV_BIT) begin : g_rsv
                assign stb_byte[gi] = rsv_r;
            end else begin : g_ins
                assign stb_byte[gi] = stb_in[gi];
            end
        end
    endgenerate

    // command latch: only bytes taken while atn is low are commands
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            cmd_r   <= `IBCD_CMD_RST;
            cmd_v_r <= 1'b0;
        end else begin
            cmd_v_r <= cmd_take;
            if (cmd_take) begin
                // bus lines are active low; bit 7 carries no command meaning
                cmd_r <= ~dio_n_in[`IBCD_GRP_MSB:0] & `IBCD_CMD_MASK;
            end
        end
    end

    // data latch: data mode bytes get no command meaning, only forwarded
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_data_r  <= `IBCD_BYTE_RST;
            rx_valid_r <= 1'b0;
        end else begin
            // a byte this device sources as status is not echoed back as data
            rx_valid_r <= byte_done & atn_n & listen_r & ~stb_src;
            if (byte_done & atn_n) begin
                rx_data_r <= ~dio_n_in;
            end
        end
    end

    // decode stage, one cycle after the latch
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            listen_r      <= 1'b0;
            talk_r        <= 1'b0;
            lpend_r       <= 1'b0;
            tpend_r       <= 1'b0;
            ppc_pend_r    <= 1'b0;
            spoll_r       <= 1'b0;
            ppen_r        <= 1'b0;
            ppl_sense_r   <= 1'b0;
            ppl_line_r    <= `IBCD_LINE_RST;
            lockout_r     <= 1'b0;
            dev_clear_r   <= 1'b0;
            go_local_r    <= 1'b0;
            trigger_r     <= 1'b0;
            take_ctrl_r   <= 1'b0;
            cmd_ignored_r <= 1'b0;
        end else begin
            dev_clear_r   <= 1'b0;
            go_local_r    <= 1'b0;
            trigger_r     <= 1'b0;
            take_ctrl_r   <= 1'b0;
            cmd_ignored_r <= 1'b0;
            if (cmd_v_r) begin
                if (grp == `IBCD_GRP_SECOND) begin
                    lpend_r <= 1'b0;
                    tpend_r <= 1'b0;
                    if (ppc_pend_r) begin
                        // poll enable or disable follows a configure
                        ppen_r      <= ~cmd_r[`IBCD_PPE_DIS_BIT];
                        ppl_sense_r <= cmd_r[`IBCD_PPE_SENSE];
                        ppl_line_r  <= cmd_r[`IBCD_PPE_LINE_MSB:0];
                    end else if (lpend_r | tpend_r) begin
                        if (cmd_r[`IBCD_ADDR_MSB:0] == my_sec) begin
                            if (lpend_r) begin
                                listen_r <= 1'b1;
                            end
                            if (tpend_r) begin
                                talk_r <= 1'b1;
                            end
                        end else if (tpend_r) begin
                            talk_r <= 1'b0;
                        end
                    end else begin
                        cmd_ignored_r <= 1'b1;
                    end
                end else begin
                    // any primary byte ends a pending secondary phase
                    ppc_pend_r <= 1'b0;
                    lpend_r    <= 1'b0;
                    tpend_r    <= 1'b0;
                    case (cmd_r)
                        `IBCD_CMD_LLO: begin
                            lockout_r <= 1'b1;
                        end
                        `IBCD_CMD_DCL: begin
                            dev_clear_r <= 1'b1;
                        end
                        `IBCD_CMD_PPU: begin
                            ppen_r <= 1'b0;
                        end
                        `IBCD_CMD_SPE: begin
                            spoll_r <= 1'b1;
                        end
                        `IBCD_CMD_SPD: begin
                            spoll_r <= 1'b0;
                        end
                        `IBCD_CMD_UNL: begin
                            listen_r <= 1'b0;
                        end
                        `IBCD_CMD_UNT: begin
                            talk_r <= 1'b0;
                        end
                        `IBCD_CMD_SDC: begin
                            dev_clear_r   <= listen_r;
                            cmd_ignored_r <= ~listen_r;
                        end
                        `IBCD_CMD_GTL: begin
                            go_local_r    <= listen_r;
                            cmd_ignored_r <= ~listen_r;
                        end
                        `IBCD_CMD_GET: begin
                            trigger_r     <= listen_r;
                            cmd_ignored_r <= ~listen_r;
                        end
                        `IBCD_CMD_PPC: begin
                            ppc_pend_r    <= listen_r;
                            cmd_ignored_r <= ~listen_r;
                        end
                        `IBCD_CMD_TCT: begin
                            take_ctrl_r   <= listen_r;
                            cmd_ignored_r <= ~listen_r;
                        end
                        default: begin
                            if (addr_hit(cmd_r, `IBCD_GRP_LISTEN, my_addr)) begin
                                if (EXT_ADDR_EN) begin
                                    lpend_r <= 1'b1;
                                end else begin
                                    listen_r <= 1'b1;
                                end
                            end else if (addr_hit(cmd_r, `IBCD_GRP_TALK, my_addr)) begin
                                if (EXT_ADDR_EN) begin
                                    tpend_r <= 1'b1;
                                end else begin
                                    talk_r <= 1'b1;
                                end
                            end else if (grp == `IBCD_GRP_TALK) begin
                                // a new talker unaddresses the old one
                                talk_r <= 1'b0;
                            end else if (grp != `IBCD_GRP_LISTEN) begin
                                cmd_ignored_r <= 1'b1;
                            end
                        end
                    endcase
                end
            end
        end
    end

    // service request: a new request in the poll cycle wins over the clear
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rsv_r <= 1'b0;
        end else begin
            rsv_r <= svc_set | (rsv_r & ~stb_taken);
        end
    end

    // acceptance of the status byte by the controller, one pulse
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            stb_sent_r <= 1'b0;
        end else begin
            stb_sent_r <= stb_taken;
        end
    end

    // data line drivers; a driven line is pulled low, so oe doubles as the true level
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            dio_oe_r    <= `IBCD_BYTE_RST;
            dio_n_out_r <= `IBCD_IDLE_HIGH;
        end else begin
            // parallel poll wins: atn low means no status byte may be on the lines
            if (pp_active) begin
                dio_oe_r    <= pp_drive;
                dio_n_out_r <= ~pp_drive;
            end else if (stb_src) begin
                dio_oe_r    <= stb_byte;
                dio_n_out_r <= ~stb_byte;
            end else begin
                dio_oe_r    <= `IBCD_BYTE_RST;
                dio_n_out_r <= `IBCD_IDLE_HIGH;
            end
        end
    end

    // service request line; released, it reads high through the bus pull-up
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            srq_oe_r    <= 1'b0;
            srq_n_out_r <= 1'b1;
        end else begin
            srq_oe_r    <= rsv_r;
            srq_n_out_r <= ~rsv_r;
        end
    end

    assign dio_n_out   = dio_n_out_r;
    assign dio_oe      = dio_oe_r;
    assign srq_n_out   = srq_n_out_r;
    assign srq_oe      = srq_oe_r;
    assign rx_data     = rx_data_r;
    assign rx_valid    = rx_valid_r;
    assign listen      = listen_r;
    assign talk        = talk_r;
    assign spoll_mode  = spoll_r;
    assign pp_enabled  = ppen_r;
    assign lockout     = lockout_r;
    assign dev_clear   = dev_clear_r;
    assign go_local    = go_local_r;
    assign trigger     = trigger_r;
    assign take_ctrl   = take_ctrl_r;
    assign cmd_ignored = cmd_ignored_r;
    assign stb_sent    = stb_sent_r;

endmodule

// ===== src/ibcd_map.vh
// command codes, byte fields and reset values of the bus command decoder
`ifndef IBCD_MAP_VH
`define IBCD_MAP_VH

// primary command codes (seven-bit, command mode only)
`define IBCD_CMD_GTL      7'h01
`define IBCD_CMD_SDC      7'h04
`define IBCD_CMD_PPC      7'h05
`define IBCD_CMD_GET      7'h08
`define IBCD_CMD_TCT      7'h09
`define IBCD_CMD_LLO      7'h11
`define IBCD_CMD_DCL      7'h14
`define IBCD_CMD_PPU      7'h15
`define IBCD_CMD_SPE      7'h18
`define IBCD_CMD_SPD      7'h19
`define IBCD_CMD_UNL      7'h3f
`define IBCD_CMD_UNT      7'h5f

// command byte layout
`define IBCD_CMD_MASK     7'h7f
`define IBCD_GRP_MSB      6
`define IBCD_GRP_LSB      5
`define IBCD_GRP_LISTEN   2'h1
`define IBCD_GRP_TALK     2'h2
`define IBCD_GRP_SECOND   2'h3
`define IBCD_ADDR_MSB     4

// secondary byte after parallel poll configure
`define IBCD_PPE_DIS_BIT  4
`define IBCD_PPE_SENSE    3
`define IBCD_PPE_LINE_MSB 2

// status byte: service request bit (weight 64)
`define IBCD_STB_RSV_BIT  6

// reset values
`define IBCD_BYTE_RST     8'h00
`define IBCD_CMD_RST      7'h00
`define IBCD_LINE_RST     3'h0
`define IBCD_IDLE_HIGH    8'hff

`endif
